// File: design/sto_cfg.svh
// constants for the six-tap video output formatter
// Function
// - each pixel clock carries six 8-bit pixels plus line valid and data valid
// - two link transmitters X and Y carry lanes, valids and pixel clock
// - lanes and valid bits launch on every rising pixel clock edge
// - both valids high only for real pixels; receiver trusts only those cycles
// - with no valid data, line valid and data valid stay low every cycle
// - transmission of a line starts only after sensor readout has completed
// - first valid cycle raises both valids, pixels 1..6 on lanes 0..5
// - each later cycle advances six pixels until the line is done
// - both valids drop together on the cycle after the last pixels
// - transmitter X port A carries lane 0 with its fixed bit order
// - transmitter X port B carries lane 1 with its fixed bit order
// - transmitter X port C carries lane 2 with its fixed bit order
// - line valid on input 24, data valid on 26, inputs 23 and 25 unused
// - transmitter Y ports D, E, F carry lanes 3..5 in the same orders
// - line valid delay depends on acquisition mode, clock speed, sensor size
// - output sequence is the same for every exposure mode
`ifndef STO_CFG_SVH
`define STO_CFG_SVH

// ****************************************
// widths
// ****************************************
`define STO_PIX_W 8
`define STO_LANES 6
`define STO_WORD_W 48
`define STO_TX_W 28
`define STO_CFG_W 5

// ****************************************
// transmitter input positions
// ****************************************
`define STO_TX_LVAL 24
`define STO_TX_DVAL 26
// per port, 5-bit input index for lane bits 7 down to 0
`define STO_MAP_A {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`define STO_MAP_B {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07}
`define STO_MAP_C {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f}
`define STO_TX_IDLE 28'h000_0000

// ****************************************
// line size (pixels) and line valid delay defaults (link cycles)
// ****************************************
`define STO_LINE_PIX 2052
`define STO_DLY_RGB 120
`define STO_DLY_RAW 360
`define STO_DLY_ERAW 380
`define STO_DLY_SIZE_STEP 40
`define STO_DLY_SPEED_STEP 200

`endif

// File: design/sto_pkg.sv
// types shared by the six-tap video output formatter
package sto_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_HAND} sto_sys_state_type;
  typedef enum logic [1:0] {LK_IDLE, LK_DELAY, LK_SEND} sto_link_state_type;
endpackage

// File: design/sto_line_mem.sv
// dual-clock line memory: written on the system clock, read on the link clock
`timescale 1ns/1ps
module sto_line_mem #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 342,
  parameter int AW = 9
) (
  // write side
  input wire logic clk_wr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic clk_rd,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_wr) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always leaves from a register
  always_ff @(posedge clk_rd) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// File: design/sto_formatter.sv
// six-tap video output formatter: line capture and link transmit logic
`timescale 1ns/1ps
`include "sto_cfg.svh"
module sto_formatter import sto_pkg::*; #(
  parameter int LINE_PIX = `STO_LINE_PIX,
  parameter int DLY_RGB = `STO_DLY_RGB,
  parameter int DLY_RAW = `STO_DLY_RAW,
  parameter int DLY_ERAW = `STO_DLY_ERAW,
  parameter int DLY_SIZE_STEP = `STO_DLY_SIZE_STEP,
  parameter int DLY_SPEED_STEP = `STO_DLY_SPEED_STEP
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // exposure and sensor readout stream
  input wire logic expo_done,
  input wire logic pix_valid,
  input wire logic [`STO_PIX_W-1:0] pix_data,
  output logic pix_ready,
  // line timing settings
  input wire logic [1:0] acq_mode,
  input wire logic clk_speed,
  input wire logic [1:0] sensor_size,
  // status
  output logic line_busy,
  // link pixel clock
  input wire logic clk_link,
  // transmitter X
  output logic [`STO_TX_W-1:0] tx_x_data,
  output logic tx_x_clk,
  // transmitter Y
  output logic [`STO_TX_W-1:0] tx_y_data,
  output logic tx_y_clk
);

  // ****************************************
  // derived sizes
  // ****************************************
  localparam int WORDS = LINE_PIX / `STO_LANES;
  localparam int AW = (WORDS > 1) ? $clog2(WORDS) : 1;
  localparam logic [AW-1:0] LAST_ADDR = AW'(WORDS - 1);
  localparam int DW = 16;

  // ****************************************
  // functions
  // ****************************************
  // place one lane's bits onto transmitter inputs by a 5-bit index table
  function automatic logic [`STO_TX_W-1:0] place_lane(
    input logic [`STO_PIX_W-1:0] lane,
    input logic [39:0] map
  );
    logic [`STO_TX_W-1:0] res;
    res = `STO_TX_IDLE;
    for (int i = 0; i < `STO_PIX_W; i++) begin
      res[map[i*5 +: 5]] = lane[i];
    end
    return res;
  endfunction

  // one transmitter word: three lanes, line valid, data valid;
  // inputs 23 and 25 are left at zero
  function automatic logic [`STO_TX_W-1:0] tx_word(
    input logic [`STO_PIX_W-1:0] lane_a,
    input logic [`STO_PIX_W-1:0] lane_b,
    input logic [`STO_PIX_W-1:0] lane_c,
    input logic vld
  );
    logic [`STO_TX_W-1:0] res;
    res = place_lane(lane_a, `STO_MAP_A)
        | place_lane(lane_b, `STO_MAP_B)
        | place_lane(lane_c, `STO_MAP_C);
    res[`STO_TX_LVAL] = vld;
    res[`STO_TX_DVAL] = vld;
    return res;
  endfunction

  // line valid delay in link cycles from {mode, speed, size}
  function automatic logic [DW-1:0] dly_cycles(
    input logic [`STO_CFG_W-1:0] cfg
  );
    int base;
    int total;
    base = DLY_RGB;
    unique case (cfg[4:3])
      2'h1: base = DLY_RAW;
      2'h2: base = DLY_ERAW;
      default: base = DLY_RGB;
    endcase
    total = base + int'(cfg[1:0]) * DLY_SIZE_STEP
          + int'(cfg[2]) * DLY_SPEED_STEP;
    if (total < 1) begin
      total = 1;
    end
    return DW'(total);
  endfunction

  // ****************************************
  // system side: capture of one line
  // ****************************************
  sto_sys_state_type sys_state_ff;
  sto_sys_state_type nxt_sys_state;
  logic [`STO_WORD_W-1:0] pack_ff;
  logic [2:0] lane_cnt_ff;
  logic [AW-1:0] wr_addr_ff;
  logic line_tgl_ff;
  logic done_s1_ff;
  logic done_s2_ff;
  logic done_s3_ff;
  logic done_tgl_ff;

  wire pix_take = (sys_state_ff == ST_FILL) && pix_valid;
  wire word_full = pix_take && (lane_cnt_ff == 3'(`STO_LANES - 1));
  wire line_full = word_full && (wr_addr_ff == LAST_ADDR);
  wire link_done = done_s2_ff ^ done_s3_ff;
  // pixel 6n+k+1 lands in lane k: newest pixel enters at the top
  wire [`STO_WORD_W-1:0] wr_word = {pix_data,
                                    pack_ff[`STO_WORD_W-1:`STO_PIX_W]};

  // readout is refused outside the fill phase so pixels are never lost
  assign pix_ready = (sys_state_ff == ST_FILL);
  assign line_busy = (sys_state_ff != ST_IDLE);

  always_comb begin
    nxt_sys_state = sys_state_ff;
    unique case (sys_state_ff)
      ST_IDLE: begin
        if (expo_done) begin
          nxt_sys_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (line_full) begin
          nxt_sys_state = ST_HAND;
        end
      end
      ST_HAND: begin
        if (link_done) begin
          nxt_sys_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_state_ff <= ST_IDLE;
    end else begin
      sys_state_ff <= nxt_sys_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pack_ff <= '0;
      lane_cnt_ff <= 3'h0;
    end else if (pix_take) begin
      pack_ff <= wr_word;
      lane_cnt_ff <= word_full ? 3'h0 : lane_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_addr_ff <= '0;
    end else if (sys_state_ff == ST_IDLE) begin
      wr_addr_ff <= '0;
    end else if (word_full && !line_full) begin
      wr_addr_ff <= wr_addr_ff + AW'(1);
    end
  end

  // a line is handed to the link only once readout has filled it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_tgl_ff <= 1'b0;
    end else if (line_full) begin
      line_tgl_ff <= ~line_tgl_ff;
    end
  end

  // end-of-line event back from the link domain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
    end else begin
      done_s1_ff <= done_tgl_ff;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
    end
  end

  // ****************************************
  // line memory
  // ****************************************
  logic [AW-1:0] rd_addr_ff;
  logic [`STO_WORD_W-1:0] rd_word;
  wire rd_en;

  // single line buffer: the system side waits in ST_HAND, so a line
  // being sent is never overwritten; costs one line of readout overlap
  sto_line_mem #(
    .WIDTH(`STO_WORD_W),
    .DEPTH(WORDS),
    .AW(AW)
  ) u_mem (
    .clk_wr(clk_sys),
    .wr_en(word_full),
    .wr_addr(wr_addr_ff),
    .wr_data(wr_word),
    .clk_rd(clk_link),
    .rd_en(rd_en),
    .rd_addr(rd_addr_ff),
    .rd_data(rd_word)
  );

  // ****************************************
  // link side: reset and crossings
  // ****************************************
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic line_s1_ff;
  logic line_s2_ff;
  logic line_s3_ff;
  logic [`STO_CFG_W-1:0] cfg_s1_ff;
  logic [`STO_CFG_W-1:0] cfg_s2_ff;

  wire link_rst = rst_s2_ff;
  wire new_line = line_s2_ff ^ line_s3_ff;
  // settings are levels that change only between lines
  wire [`STO_CFG_W-1:0] cfg_sys = {acq_mode, clk_speed, sensor_size};

  always_ff @(posedge clk_link) begin
    rst_s1_ff <= rst;
    rst_s2_ff <= rst_s1_ff;
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      line_s1_ff <= 1'b0;
      line_s2_ff <= 1'b0;
      line_s3_ff <= 1'b0;
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
    end else begin
      line_s1_ff <= line_tgl_ff;
      line_s2_ff <= line_s1_ff;
      line_s3_ff <= line_s2_ff;
      cfg_s1_ff <= cfg_sys;
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  // ****************************************
  // link side: line sequencer
  // ****************************************
  sto_link_state_type lk_state_ff;
  sto_link_state_type nxt_lk_state;
  logic [DW-1:0] dly_cnt_ff;
  logic vld_ff;

  wire dly_over = (dly_cnt_ff <= DW'(1));
  wire last_word = (rd_addr_ff == LAST_ADDR);
  // the exposure mode never enters here: one sequence for all modes
  assign rd_en = (lk_state_ff == LK_SEND);

  always_comb begin
    nxt_lk_state = lk_state_ff;
    unique case (lk_state_ff)
      LK_IDLE: begin
        if (new_line) begin
          nxt_lk_state = LK_DELAY;
        end
      end
      LK_DELAY: begin
        if (dly_over) begin
          nxt_lk_state = LK_SEND;
        end
      end
      LK_SEND: begin
        if (last_word) begin
          nxt_lk_state = LK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      lk_state_ff <= LK_IDLE;
    end else begin
      lk_state_ff <= nxt_lk_state;
    end
  end

  // delay before line valid follows the synchronised settings
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      dly_cnt_ff <= '0;
    end else if (lk_state_ff == LK_IDLE && new_line) begin
      dly_cnt_ff <= dly_cycles(cfg_s2_ff);
    end else if (lk_state_ff == LK_DELAY) begin
      dly_cnt_ff <= dly_cnt_ff - DW'(1);
    end
  end

  // one word of six pixels per cycle, first word holds pixels 1..6
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      rd_addr_ff <= '0;
    end else if (lk_state_ff != LK_SEND) begin
      rd_addr_ff <= '0;
    end else if (!last_word) begin
      rd_addr_ff <= rd_addr_ff + AW'(1);
    end
  end

  // reported once the last word has left the memory, so busy covers the send
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      done_tgl_ff <= 1'b0;
    end else if (vld_ff && !rd_en) begin
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // valid follows the memory read by one cycle, matching its data
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= rd_en;
    end
  end

  // ****************************************
  // link side: transmitter inputs
  // ****************************************
  logic [`STO_TX_W-1:0] tx_x_ff;
  logic [`STO_TX_W-1:0] tx_y_ff;

  // idle cycles send zero lanes so stale pixels never look valid
  wire [`STO_WORD_W-1:0] send_word = vld_ff ? rd_word : '0;
  wire [`STO_PIX_W-1:0] lane_0 = send_word[0 +: `STO_PIX_W];
  wire [`STO_PIX_W-1:0] lane_1 = send_word[8 +: `STO_PIX_W];
  wire [`STO_PIX_W-1:0] lane_2 = send_word[16 +: `STO_PIX_W];
  wire [`STO_PIX_W-1:0] lane_3 = send_word[24 +: `STO_PIX_W];
  wire [`STO_PIX_W-1:0] lane_4 = send_word[32 +: `STO_PIX_W];
  wire [`STO_PIX_W-1:0] lane_5 = send_word[40 +: `STO_PIX_W];

  // launched on every rising link edge, no enable
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      tx_x_ff <= `STO_TX_IDLE;
      tx_y_ff <= `STO_TX_IDLE;
    end else begin
      tx_x_ff <= tx_word(lane_0, lane_1, lane_2, vld_ff);
      tx_y_ff <= tx_word(lane_3, lane_4, lane_5, vld_ff);
    end
  end

  // lane words and both valids leave from flops on the same edge
  assign tx_x_data = tx_x_ff;
  assign tx_y_data = tx_y_ff;
  // the pixel clock input of each transmitter is the link clock itself
  assign tx_x_clk = clk_link;
  assign tx_y_clk = clk_link;

endmodule

// File: tb/sto_formatter_chk.sv
// assertions for the six-tap video output formatter
`timescale 1ns/1ps
module sto_formatter_chk #(
  parameter int LINE_PIX = 12
) (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  // watched ports
  input wire logic expo_done,
  input wire logic pix_ready,
  input wire logic line_busy,
  input wire logic [27:0] tx_x_data,
  input wire logic [27:0] tx_y_data
);
  logic lv;
  logic lrst;
  logic [2:0] lrst_ff;
  logic [15:0] run_ff;
  logic [15:0] nxt_run;
  assign lv = tx_x_data[24];
  assign nxt_run = lv ? run_ff + 16'h0001 : 16'h0000;
  // link outputs settle a few link edges after rst falls, so link checks
  // wait for this local copy of reset to clear
  assign lrst = rst || (lrst_ff != 3'b000);
  always_ff @(posedge clk_link) begin
    lrst_ff <= {lrst_ff[1:0], rst};
  end
  // run length of line valid, checked when it falls
  always_ff @(posedge clk_link) begin
    run_ff <= lrst ? 16'h0000 : nxt_run;
  end
  sequence s_arm;
    expo_done && !line_busy;
  endsequence
  sequence s_line_end;
    $fell(lv);
  endsequence
  chk_arm_busy: assert property (@(posedge clk_sys) disable iff (rst)
    s_arm |=> line_busy && pix_ready) else $error("line not armed");
  chk_ready_busy: assert property (@(posedge clk_sys) disable iff (rst)
    pix_ready |-> line_busy) else $error("ready while not busy");
  chk_valid_pair: assert property (@(posedge clk_link) disable iff (lrst)
    tx_x_data[26] == lv) else $error("valid bits differ");
  chk_xy_match: assert property (@(posedge clk_link) disable iff (lrst)
    tx_y_data[24] == lv && tx_y_data[26] == lv) else $error("x y differ");
  chk_unused_low: assert property (@(posedge clk_link) disable iff (lrst)
    !tx_x_data[23] && !tx_x_data[25] && !tx_y_data[23] && !tx_y_data[25])
    else $error("unused input driven");
  chk_idle_zero: assert property (@(posedge clk_link) disable iff (lrst)
    !lv |-> tx_x_data == 28'h000_0000 && tx_y_data == 28'h000_0000)
    else $error("idle output not zero");
  chk_line_len: assert property (@(posedge clk_link) disable iff (lrst)
    s_line_end |-> run_ff == 16'(LINE_PIX / 6)) else $error("line length");
  chk_send_after: assert property (@(posedge clk_link) disable iff (lrst)
    lv |-> !pix_ready && line_busy) else $error("send before readout");
endmodule

bind sto_formatter sto_formatter_chk #(.LINE_PIX(LINE_PIX)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .clk_link(clk_link),
  .expo_done(expo_done),
  .pix_ready(pix_ready),
  .line_busy(line_busy),
  .tx_x_data(tx_x_data),
  .tx_y_data(tx_y_data)
);

// File: tb/sto_grabber.sv
// frame grabber model: two link receivers rebuilding six pixel lanes
`timescale 1ns/1ps
module sto_grabber (
  // link clock and transmitter inputs
  input wire logic clk_link,
  input wire logic [27:0] tx_x_data,
  input wire logic [27:0] tx_y_data
);
  // input position of lane bits 0..7 for ports A/D, B/E, C/F
  localparam int MAP[24] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8, 9, 12, 13, 14,
    10, 11, 15, 18, 19, 20, 21, 22, 16, 17};
  logic [7:0] rx_q[$];
  int cyc = 0;
  int first_cyc = 0;
  logic prev = 1'b0;
  always @(posedge clk_link) begin : rx
    logic [7:0] px;
    logic [27:0] d;
    logic vld;
    vld = tx_x_data[24] && tx_x_data[26] && tx_y_data[24] && tx_y_data[26];
    if (vld && !prev) first_cyc = cyc;
    if (vld) begin
      for (int k = 0; k < 6; k++) begin
        d = (k < 3) ? tx_x_data : tx_y_data;
        for (int b = 0; b < 8; b++) px[b] = d[MAP[(k % 3) * 8 + b]];
        rx_q.push_back(px);
      end
    end
    prev = vld;
    cyc++;
  end
endmodule

// File: tb/test_sto_formatter.sv
// self-checking bench for the six-tap video output formatter
`timescale 1ns/1ps
`include "sto_cfg.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module test_sto_formatter;
  localparam int LP = 12;
  localparam int DR = 5, DW = 9, DE = 11, DS = 3, DP = 7;
  logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1;
  logic expo_done = 1'b0, pix_valid = 1'b0, clk_speed = 1'b0;
  logic [`STO_PIX_W-1:0] pix_data = 8'h00, e8, g8;
  logic [1:0] acq_mode = 2'h0, sensor_size = 2'h0;
  logic pix_ready, line_busy, first = 1'b1, tx_x_clk, tx_y_clk;
  logic [`STO_TX_W-1:0] tx_x_data, tx_y_data;
  int num_errors = 0, n_compared = 0, offs = 0, t0;
  logic [7:0] exp_q[$];
  always #5 clk_sys = ~clk_sys;
  // link clock offset so its edges never meet the system clock edges
  initial begin
    #2.7;
    forever #6 clk_link = ~clk_link;
  end
  sto_formatter #(.LINE_PIX(LP), .DLY_RGB(DR), .DLY_RAW(DW), .DLY_ERAW(DE),
    .DLY_SIZE_STEP(DS), .DLY_SPEED_STEP(DP)) DUT (
    .clk_sys(clk_sys), .rst(rst), .expo_done(expo_done),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
    .acq_mode(acq_mode), .clk_speed(clk_speed), .sensor_size(sensor_size),
    .line_busy(line_busy), .clk_link(clk_link), .tx_x_data(tx_x_data),
    .tx_x_clk(tx_x_clk), .tx_y_data(tx_y_data), .tx_y_clk(tx_y_clk));
  sto_grabber u_grab (.clk_link(clk_link), .tx_x_data(tx_x_data),
    .tx_y_data(tx_y_data));
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // which 0: wait for fill phase, 1: wait for line sent
  task automatic wait_until(input int which);
    int n;
    n = 0;
    while ((which == 0 ? pix_ready !== 1'b1 : line_busy !== 1'b0) &&
           n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("CHECK FAILED wait exp 1 got 0");
      tally_and_finish();
    end
  endtask
  task automatic send_line(input int m, input int sp, input int sz);
    int d, i, meas;
    logic tk;
    d = (m == 1 ? DW : m == 2 ? DE : DR) + sz * DS + sp * DP;
    acq_mode = m[1:0];
    clk_speed = sp[0];
    sensor_size = sz[1:0];
    expo_done = 1'b1;
    @(posedge clk_sys);
    #1;
    expo_done = 1'b0;
    wait_until(0);
    i = 0;
    while (i < LP) begin
      pix_valid = ($urandom % 4) != 0;
      pix_data = 8'($urandom);
      tk = pix_valid && pix_ready === 1'b1;
      @(posedge clk_sys);
      t0 = u_grab.cyc;
      if (tk) begin
        exp_q.push_back(pix_data);
        i++;
      end
      #1;
      `CHK("pixel clock x", clk_link, tx_x_clk)
      `CHK("pixel clock y", clk_link, tx_y_clk)
    end
    // a pixel offered after the line is full must be ignored
    pix_data = 8'hff;
    @(posedge clk_sys);
    #1;
    pix_valid = 1'b0;
    wait_until(1);
    meas = u_grab.first_cyc - t0 - d;
    if (first) offs = meas;
    first = 1'b0;
    `CHK("delay", 1'b1, (meas - offs) inside {[-2:2]})
    `CHK("count", exp_q.size(), u_grab.rx_q.size())
    while (exp_q.size() > 0 && u_grab.rx_q.size() > 0) begin
      e8 = exp_q.pop_front();
      g8 = u_grab.rx_q.pop_front();
      `CHK("pixel", e8, g8)
    end
    exp_q.delete();
    u_grab.rx_q.delete();
  endtask
  initial begin
    t0 = $urandom(10840);
    // held long enough for the link side to see reset too
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_link);
    @(posedge clk_sys);
    #1;
    for (int m = 0; m < 4; m++)
      for (int sp = 0; sp < 2; sp++)
        for (int sz = 0; sz < 4; sz++) send_line(m, sp, sz);
    tally_and_finish();
  end
endmodule
